// ---- design/aerhc_top.sv ----
// Axis enable, error acknowledge and homing control with an AHB-Lite register file
`timescale 1ns/1ns
// Behaviour
// - Drive enable out, then wait drive ready
// - Drive ready seen: status and enabled flag true
// - No drive interface: enabled at once
// - Disable done: busy, status, flag false together
// - Acknowledge clears operating and configuration errors
// - Acknowledge starts only on trigger rise
// - Acknowledge neither aborted nor aborting motion
// - Acknowledge success: done, error flag cleared; busy meanwhile
// - Acknowledge failure: error with cause, detail codes
// - Mode 0: position set to homing value
// - Mode 1: homing value added to position
// - Mode 2: no own motion, homed on switch
// - Mode 3: device performs reference approach itself
// - Stop selection 0 decelerates, 1 stops pulses
// - Status stays true until standstill
// - Dropping enable aborts active motion tasks
// - Homing starts only on trigger rise
`include "aerhc_map.svh"
module aerhc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Drive and axis pins
  output logic drive_enable,
  input wire logic drive_ready,
  input wire logic drive_fault,
  input wire logic ref_switch,
  output logic pulse_out,
  output logic dir_out,
  // Acknowledge failure codes
  output logic [15:0] error_cause_code,
  output logic [15:0] error_detail_code
);
  import aerhc_pkg::*;
  aerhc_st_t st;
  aerhc_st_t next_st;
  aerhc_bus_t bus;
  aerhc_status_t stat;
  aerhc_ev_t ev_lvl;
  aerhc_ev_t ev_rise;
  logic [31:0] rdata;
  logic tick, cfg_bad, ack_clear, status, power_busy, standstill;
  logic ready_s, fault_s, ref_s, ack_rise, home_rise, ref_rise, fault_rise;

  function automatic logic [31:0] sext(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : sext

  function automatic logic [15:0] toward_zero(input logic [15:0] v, input logic [15:0] d);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : v;
    if (mag <= d) begin
      return 16'h0000;
    end
    return v[15] ? 16'(v + d) : 16'(v - d);
  endfunction : toward_zero

  aerhc_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .bus(bus),
    .rdata(rdata)
  );

  assign ready_s = st.sync2[0];
  assign fault_s = st.sync2[1];
  assign ref_s = st.sync2[2];
  assign ev_lvl = {fault_s, ref_s, st.home_trg, st.ack_trg};

  aerhc_edge u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .lvl(ev_lvl),
    .rise(ev_rise)
  );

  assign ack_rise = ev_rise[`AERHC_EV_ACK];
  assign home_rise = ev_rise[`AERHC_EV_HOME];
  assign ref_rise = ev_rise[`AERHC_EV_REF];
  assign fault_rise = ev_rise[`AERHC_EV_FAULT];
  assign tick = (st.tick_cnt == 6'h00);
  // A zero deceleration is an invalid setting and stands as a configuration error
  assign cfg_bad = (st.decel == 16'h0000);
  assign status = (st.en_st == AERHC_EN_ON) || (st.en_st == AERHC_EN_STOP);
  assign power_busy = st.en_req | status;
  assign standstill = (st.cur_vel == 16'h0000);

  always_comb begin
    next_st = st;
    ack_clear = 1'b0;
    next_st.sync1 = {ref_switch, drive_fault, drive_ready};
    next_st.sync2 = st.sync1;
    if (bus.we) begin
      case (bus.addr)
        `AERHC_OFS_CTRL: begin
          next_st.en_req = bus.wdata[`AERHC_CTRL_EN];
          next_st.stop_sel = bus.wdata[`AERHC_CTRL_STOP];
          next_st.drv_if = bus.wdata[`AERHC_CTRL_DRVIF];
          next_st.ack_trg = bus.wdata[`AERHC_CTRL_ACK];
          next_st.home_trg = bus.wdata[`AERHC_CTRL_HOME];
          next_st.home_mode = bus.wdata[`AERHC_CTRL_MODE +: 2];
        end
        `AERHC_OFS_HOME_POS: next_st.home_pos = bus.wdata;
        `AERHC_OFS_CMD_VEL: next_st.cmd_vel = bus.wdata[15:0];
        `AERHC_OFS_DECEL: next_st.decel = bus.wdata[15:0];
        default: ;
      endcase
    end
    next_st.tick_cnt = tick ? 6'(`AERHC_TICK_CYC - 1) : 6'(st.tick_cnt - 6'h01);

    unique case (st.en_st)
      AERHC_EN_OFF: begin
        // Homing is lost whenever the axis is disabled
        next_st.homed = 1'b0;
        if (st.en_req && !st.err_flag) begin
          next_st.stop_lat = st.stop_sel;
          next_st.stop_imm = 1'b0;
          if (st.drv_if) begin
            next_st.drv_en = 1'b1;
            next_st.en_st = AERHC_EN_WAIT;
          end else begin
            next_st.en_st = AERHC_EN_ON;
          end
        end
      end
      AERHC_EN_WAIT: begin
        if (!st.en_req || st.err_flag) begin
          next_st.drv_en = 1'b0;
          next_st.en_st = AERHC_EN_OFF;
        end else if (ready_s) begin
          next_st.en_st = AERHC_EN_ON;
        end
      end
      AERHC_EN_ON: begin
        if (!st.en_req || st.err_flag) begin
          // An error stop never ramps: the fault may lie in the ramp itself
          next_st.stop_imm = st.err_flag | st.stop_lat;
          next_st.en_st = AERHC_EN_STOP;
        end
      end
      AERHC_EN_STOP: begin
        if (st.err_flag) begin
          next_st.stop_imm = 1'b1;
        end
        if (standstill) begin
          // Homed drops with status, not a cycle later
          next_st.homed = 1'b0;
          next_st.drv_en = 1'b0;
          next_st.en_st = AERHC_EN_OFF;
        end
      end
    endcase

    if (st.en_st == AERHC_EN_ON) begin
      if (st.hm_st == AERHC_HM_ACTIVE) begin
        next_st.cur_vel = `AERHC_HOME_VEL;
      end else if (tick) begin
        next_st.cur_vel = st.cmd_vel;
      end
    end else if (st.en_st == AERHC_EN_STOP) begin
      if (st.stop_imm) begin
        next_st.cur_vel = 16'h0000;
      end else if (tick) begin
        next_st.cur_vel = toward_zero(st.cur_vel, st.decel);
      end
    end else begin
      next_st.cur_vel = 16'h0000;
    end
    if (tick) begin
      next_st.pos = st.pos + sext(st.cur_vel);
    end
    next_st.pulse = tick && !standstill && !((st.en_st == AERHC_EN_STOP) && st.stop_imm);
    next_st.dir = st.cur_vel[15];

    // Acknowledge runs to its end whatever motion does, and touches no motion state
    if (st.ack_busy) begin
      if (st.ack_cnt == 3'h0) begin
        next_st.ack_busy = 1'b0;
        if (cfg_bad) begin
          next_st.ack_error = 1'b1;
          next_st.ack_err = '{detail: `AERHC_DET_ACK_CFG, cause: `AERHC_CAUSE_ACK_CFG};
        end else if (fault_s) begin
          next_st.ack_error = 1'b1;
          next_st.ack_err = '{detail: `AERHC_DET_ACK_OP, cause: `AERHC_CAUSE_ACK_OP};
        end else begin
          next_st.ack_done = 1'b1;
          ack_clear = 1'b1;
        end
      end else begin
        next_st.ack_cnt = 3'(st.ack_cnt - 3'h1);
      end
    end else if (ack_rise) begin
      next_st.ack_busy = 1'b1;
      next_st.ack_cnt = 3'(`AERHC_ACK_CYC - 1);
      next_st.ack_done = 1'b0;
      next_st.ack_error = 1'b0;
    end
    // A new fault in the clearing cycle still sets the flag
    next_st.err_flag = fault_rise | cfg_bad | (st.err_flag & ~ack_clear);

    unique case (st.hm_st)
      AERHC_HM_IDLE: begin
        if (home_rise) begin
          next_st.hm_done = 1'b0;
          next_st.hm_error = 1'b0;
          next_st.hm_abort = 1'b0;
          if (st.en_st != AERHC_EN_ON) begin
            next_st.hm_error = 1'b1;
            next_st.hm_err = '{detail: `AERHC_DET_HOME_OFF, cause: `AERHC_CAUSE_HOME_OFF};
          end else begin
            unique case (st.home_mode)
              2'h0: begin
                next_st.pos = st.home_pos;
                next_st.homed = 1'b1;
                next_st.hm_done = 1'b1;
              end
              2'h1: begin
                // A motion tick in this cycle is dropped in favour of the correction
                next_st.pos = st.pos + st.home_pos;
                next_st.homed = 1'b1;
                next_st.hm_done = 1'b1;
              end
              2'h2: begin
                next_st.hm_st = AERHC_HM_PASSIVE;
              end
              2'h3: begin
                next_st.homed = 1'b0;
                next_st.hm_st = AERHC_HM_ACTIVE;
              end
            endcase
          end
        end
      end
      AERHC_HM_PASSIVE, AERHC_HM_ACTIVE: begin
        if (st.en_st != AERHC_EN_ON) begin
          next_st.hm_abort = 1'b1;
          next_st.hm_st = AERHC_HM_IDLE;
        end else if (ref_rise) begin
          next_st.pos = st.home_pos;
          next_st.homed = 1'b1;
          next_st.hm_done = 1'b1;
          next_st.hm_st = AERHC_HM_IDLE;
          if (st.hm_st == AERHC_HM_ACTIVE) begin
            next_st.cur_vel = 16'h0000;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.en_st <= AERHC_EN_OFF;
      st.hm_st <= AERHC_HM_IDLE;
      st.decel <= `AERHC_RST_DECEL;
    end else begin
      st <= next_st;
    end
  end

  assign stat = '{hm_abort: st.hm_abort, hm_error: st.hm_error, hm_done: st.hm_done,
                  hm_busy: (st.hm_st != AERHC_HM_IDLE), ack_error: st.ack_error,
                  ack_done: st.ack_done, ack_busy: st.ack_busy, homed: st.homed,
                  drv_en: st.drv_en, err_flag: st.err_flag, standstill: standstill,
                  power_busy: power_busy, status: status};

  always_comb begin
    rdata = 32'h00000000;
    case (bus.addr)
      `AERHC_OFS_CTRL: begin
        rdata[`AERHC_CTRL_EN] = st.en_req;
        rdata[`AERHC_CTRL_STOP] = st.stop_sel;
        rdata[`AERHC_CTRL_DRVIF] = st.drv_if;
        rdata[`AERHC_CTRL_ACK] = st.ack_trg;
        rdata[`AERHC_CTRL_HOME] = st.home_trg;
        rdata[`AERHC_CTRL_MODE +: 2] = st.home_mode;
      end
      `AERHC_OFS_HOME_POS: rdata = st.home_pos;
      `AERHC_OFS_CMD_VEL: rdata = {16'h0000, st.cmd_vel};
      `AERHC_OFS_DECEL: rdata = {16'h0000, st.decel};
      `AERHC_OFS_STATUS: rdata = {19'h00000, stat};
      `AERHC_OFS_POSITION: rdata = st.pos;
      `AERHC_OFS_ACK_ERR: rdata = st.ack_err;
      `AERHC_OFS_HOME_ERR: rdata = st.hm_err;
      default: rdata = 32'h00000000;
    endcase
  end

  assign drive_enable = st.drv_en;
  assign pulse_out = st.pulse;
  assign dir_out = st.dir;
  assign error_cause_code = st.ack_err.cause;
  assign error_detail_code = st.ack_err.detail;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_drive_wait;
    (st.en_st == AERHC_EN_OFF && st.en_req && st.drv_if && !st.err_flag)
      |=> (st.en_st == AERHC_EN_WAIT) && drive_enable && !status;
  endproperty
  a_drive_wait: assert property (p_drive_wait) else $error("drive enable not raised before ready wait");

  property p_ready_on;
    (st.en_st == AERHC_EN_WAIT && st.en_req && !st.err_flag && ready_s) |=> status && stat.status;
  endproperty
  a_ready_on: assert property (p_ready_on) else $error("axis not enabled after drive ready");

  property p_no_drive;
    (st.en_st == AERHC_EN_OFF && st.en_req && !st.drv_if && !st.err_flag) |=> status ##0 !drive_enable;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("axis without drive not enabled at once");

  property p_off_together;
    ($fell(status) && !st.en_req) |-> !power_busy && !stat.status && !drive_enable;
  endproperty
  a_off_together: assert property (p_off_together) else $error("disable outputs not false together");

  property p_ack_run;
    (ack_rise && !st.ack_busy) |=> st.ack_busy [*5] ##1 !st.ack_busy;
  endproperty
  a_ack_run: assert property (p_ack_run) else $error("acknowledge busy length wrong");

  property p_ack_level;
    (st.ack_trg && $past(st.ack_trg) && !st.ack_busy) |=> !st.ack_busy;
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("acknowledge restarted by steady level");

  property p_ack_ok;
    (st.ack_busy && st.ack_cnt == 3'h0 && !cfg_bad && !fault_s) |=> st.ack_done && !st.err_flag;
  endproperty
  a_ack_ok: assert property (p_ack_ok) else $error("acknowledge did not clear error");

  property p_ack_fail;
    (st.ack_busy && st.ack_cnt == 3'h0 && cfg_bad)
      |=> st.ack_error && (error_cause_code == `AERHC_CAUSE_ACK_CFG) && (error_detail_code == `AERHC_DET_ACK_CFG);
  endproperty
  a_ack_fail: assert property (p_ack_fail) else $error("acknowledge failure codes wrong");

  property p_ack_keeps_motion;
    (st.ack_busy && st.en_st == AERHC_EN_ON && st.en_req && !st.err_flag) |=> st.en_st == AERHC_EN_ON;
  endproperty
  a_ack_keeps_motion: assert property (p_ack_keeps_motion) else $error("acknowledge disturbed motion");

  property p_home_abs;
    (st.hm_st == AERHC_HM_IDLE && home_rise && st.en_st == AERHC_EN_ON && st.home_mode == 2'h0)
      |=> (st.pos == $past(st.home_pos)) && st.hm_done && st.homed;
  endproperty
  a_home_abs: assert property (p_home_abs) else $error("absolute homing position wrong");

  property p_home_rel;
    (st.hm_st == AERHC_HM_IDLE && home_rise && st.en_st == AERHC_EN_ON && st.home_mode == 2'h1)
      |=> st.pos == 32'($past(st.pos) + $past(st.home_pos));
  endproperty
  a_home_rel: assert property (p_home_rel) else $error("relative homing position wrong");

  property p_passive;
    (st.hm_st == AERHC_HM_PASSIVE && st.en_st == AERHC_EN_ON && ref_rise) |=> st.homed && st.hm_done;
  endproperty
  a_passive: assert property (p_passive) else $error("passive homing missed switch");

  property p_active;
    (st.hm_st == AERHC_HM_ACTIVE && st.en_st == AERHC_EN_ON && !ref_rise) |=> st.cur_vel == `AERHC_HOME_VEL;
  endproperty
  a_active: assert property (p_active) else $error("active homing not moving");

  property p_imm_stop;
    (st.en_st == AERHC_EN_STOP && st.stop_imm) |=> standstill && !pulse_out;
  endproperty
  a_imm_stop: assert property (p_imm_stop) else $error("immediate stop still moving");

  property p_status_hold;
    (st.en_st == AERHC_EN_STOP && !standstill) |=> status;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status dropped before standstill");

  property p_home_abort;
    (st.hm_st != AERHC_HM_IDLE && st.en_st != AERHC_EN_ON) |=> (st.hm_st == AERHC_HM_IDLE) && st.hm_abort;
  endproperty
  a_home_abort: assert property (p_home_abort) else $error("homing not aborted by disable");

  property p_edge;
    (home_rise || ack_rise) |-> ($rose(st.home_trg) || $rose(st.ack_trg));
  endproperty
  a_edge: assert property (p_edge) else $error("trigger rise without edge");

  c_drive_on: cover property ((st.en_st == AERHC_EN_WAIT) ##[1:50] (st.en_st == AERHC_EN_ON));
  c_ack_ok: cover property ($rose(st.ack_done));
  c_ramp_stop: cover property ((st.en_st == AERHC_EN_STOP && !st.stop_imm && !standstill) ##[1:1000] !status);
  c_active_home: cover property ((st.hm_st == AERHC_HM_ACTIVE) ##[1:1000] st.hm_done);
endmodule : aerhc_top

// ---- shared/aerhc_map.svh ----
// Register offsets, field positions, reset values, codes and timing of the axis block
`ifndef AERHC_MAP_SVH
`define AERHC_MAP_SVH
`define AERHC_OFS_CTRL 8'h00
`define AERHC_OFS_HOME_POS 8'h04
`define AERHC_OFS_CMD_VEL 8'h08
`define AERHC_OFS_DECEL 8'h0C
`define AERHC_OFS_STATUS 8'h10
`define AERHC_OFS_POSITION 8'h14
`define AERHC_OFS_ACK_ERR 8'h18
`define AERHC_OFS_HOME_ERR 8'h1C
`define AERHC_CTRL_EN 0
`define AERHC_CTRL_STOP 1
`define AERHC_CTRL_DRVIF 2
`define AERHC_CTRL_ACK 3
`define AERHC_CTRL_HOME 4
`define AERHC_CTRL_MODE 5
`define AERHC_RST_DECEL 16'h0010
`define AERHC_HOME_VEL 16'h0008
`define AERHC_CAUSE_ACK_CFG 16'h8001
`define AERHC_DET_ACK_CFG 16'h0001
`define AERHC_CAUSE_ACK_OP 16'h8002
`define AERHC_DET_ACK_OP 16'h0002
`define AERHC_CAUSE_HOME_OFF 16'h8003
`define AERHC_DET_HOME_OFF 16'h0003
`define AERHC_CLK_NS 20
`define AERHC_TICK_NS 1000
`define AERHC_TICK_CYC (`AERHC_TICK_NS / `AERHC_CLK_NS)
`define AERHC_ACK_NS 100
`define AERHC_ACK_CYC ((`AERHC_ACK_NS + `AERHC_CLK_NS - 1) / `AERHC_CLK_NS)
`define AERHC_EV_ACK 0
`define AERHC_EV_HOME 1
`define AERHC_EV_REF 2
`define AERHC_EV_FAULT 3
`endif

// ---- shared/aerhc_pkg.sv ----
// Types shared by the axis enable, acknowledge and homing block
package aerhc_pkg;
  typedef enum logic [3:0] {
    AERHC_EN_OFF = 4'h1, AERHC_EN_WAIT = 4'h2, AERHC_EN_ON = 4'h4, AERHC_EN_STOP = 4'h8
  } aerhc_en_st_t;
  typedef enum logic [2:0] {
    AERHC_HM_IDLE = 3'h1, AERHC_HM_PASSIVE = 3'h2, AERHC_HM_ACTIVE = 3'h4
  } aerhc_hm_st_t;
  typedef logic [3:0] aerhc_ev_t;
  typedef struct packed {
    logic [15:0] detail;
    logic [15:0] cause;
  } aerhc_err_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
  } aerhc_bus_t;
  typedef struct packed {
    logic hm_abort;
    logic hm_error;
    logic hm_done;
    logic hm_busy;
    logic ack_error;
    logic ack_done;
    logic ack_busy;
    logic homed;
    logic drv_en;
    logic err_flag;
    logic standstill;
    logic power_busy;
    logic status;
  } aerhc_status_t;
  typedef struct packed {
    logic wpend;
    logic rpend;
    logic mapped;
    logic [7:0] addr;
    logic [31:0] rdata;
  } aerhc_ahb_st_t;
  typedef struct packed {
    aerhc_ev_t prev;
  } aerhc_edge_st_t;
  typedef struct packed {
    aerhc_en_st_t en_st;
    aerhc_hm_st_t hm_st;
    logic en_req;
    logic stop_sel;
    logic drv_if;
    logic ack_trg;
    logic home_trg;
    logic [1:0] home_mode;
    logic [31:0] home_pos;
    logic [15:0] cmd_vel;
    logic [15:0] decel;
    logic stop_lat;
    logic stop_imm;
    logic drv_en;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [31:0] pos;
    logic [15:0] cur_vel;
    logic [5:0] tick_cnt;
    logic pulse;
    logic dir;
    logic homed;
    logic err_flag;
    logic ack_busy;
    logic [2:0] ack_cnt;
    logic ack_done;
    logic ack_error;
    aerhc_err_t ack_err;
    logic hm_done;
    logic hm_error;
    logic hm_abort;
    aerhc_err_t hm_err;
  } aerhc_st_t;
endpackage : aerhc_pkg

// ---- design/aerhc_edge.sv ----
// Rising edge detector for the trigger and event levels
`timescale 1ns/1ns
module aerhc_edge (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Levels in, one-cycle rises out
  input wire aerhc_pkg::aerhc_ev_t lvl,
  output aerhc_pkg::aerhc_ev_t rise
);
  import aerhc_pkg::*;
  aerhc_edge_st_t st;
  aerhc_edge_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.prev = lvl;
  end

  // A level held high gives one rise only
  assign rise = lvl & ~st.prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : aerhc_edge

// ---- design/aerhc_ahb.sv ----
// AHB-Lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ns
module aerhc_ahb (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register side
  output aerhc_pkg::aerhc_bus_t bus,
  input wire logic [31:0] rdata
);
  import aerhc_pkg::*;
  aerhc_ahb_st_t st;
  aerhc_ahb_st_t next_st;
  logic go;

  assign go = hsel & htrans[1] & hready;

  always_comb begin
    next_st = st;
    next_st.wpend = go & hwrite;
    next_st.rpend = go & ~hwrite;
    if (go) begin
      next_st.addr = haddr[7:0];
      next_st.mapped = (haddr[31:8] == 24'h000000);
    end
    // The wait cycle lets a write in the previous data phase land before the read
    if (st.rpend) begin
      next_st.rdata = st.mapped ? rdata : 32'h00000000;
    end
  end

  assign bus.we = st.wpend & st.mapped;
  assign bus.addr = st.addr;
  assign bus.wdata = hwdata;
  assign hreadyout = ~st.rpend;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : aerhc_ahb

// ---- sim/aerhc_drive.sv ----
// Drive model: ready follows enable after a settling delay
`timescale 1ns/1ns
module aerhc_drive #(parameter int DLY = 7) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Drive pins
  input wire logic drive_enable,
  output logic drive_ready
);
  logic [3:0] cnt;
  // Power needs time to settle, so ready never follows enable at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 4'h0;
    else if (!drive_enable) cnt <= 4'h0;
    else if (cnt != 4'(DLY)) cnt <= cnt + 4'h1;
  end
  assign drive_ready = drive_enable && cnt == 4'(DLY);
endmodule : aerhc_drive

// ---- sim/aerhc_tb_top.sv ----
// Testbench for the axis block: bus tasks and checked sequences
`timescale 1ns/1ns
module aerhc_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic drive_fault = 1'b0;
  logic ref_switch = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, drive_enable, drive_ready, pulse_out, dir_out;
  logic [15:0] cause, detail;
  int errors = 0;
  int n_checks = 0;
  int npulse = 0;
  int p0;
  always #10 hclk = ~hclk;
  always @(posedge hclk) if (pulse_out === 1'b1) npulse++;
  aerhc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .drive_enable(drive_enable), .drive_ready(drive_ready),
    .drive_fault(drive_fault), .ref_switch(ref_switch), .pulse_out(pulse_out), .dir_out(dir_out),
    .error_cause_code(cause), .error_detail_code(detail));
  aerhc_drive drv_u (.hclk(hclk), .hresetn(hresetn), .drive_enable(drive_enable), .drive_ready(drive_ready));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rchk
  // Clear the trigger first so the next write is a fresh rise
  task automatic ack;
    xfer(1'b1, 8'h00, 32'h5);
    xfer(1'b1, 8'h00, 32'hD);
  endtask : ack
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("decel_rst", 8'h0C, 32'hFFFFFFFF, 32'h10);
    rchk("ctrl_rst", 8'h00, 32'hFFFFFFFF, 32'h0);
    rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    xfer(1'b1, 8'h00, 32'h3);
    rchk("en_nodrv", 8'h10, 32'h11, 32'h1);
    xfer(1'b1, 8'h04, 32'h100);
    xfer(1'b1, 8'h00, 32'h13);
    rchk("pos_m0", 8'h14, 32'hFFFFFFFF, 32'h100);
    rchk("homed_m0", 8'h10, 32'h420, 32'h420);
    xfer(1'b1, 8'h00, 32'h33);
    rchk("no_rise", 8'h14, 32'hFFFFFFFF, 32'h100);
    xfer(1'b1, 8'h00, 32'h23);
    xfer(1'b1, 8'h00, 32'h33);
    rchk("pos_m1", 8'h14, 32'hFFFFFFFF, 32'h200);
    rchk("still", 8'h10, 32'h4, 32'h4);
    xfer(1'b1, 8'h00, 32'h0);
    rchk("off", 8'h10, 32'h23, 32'h0);
    xfer(1'b1, 8'h08, 32'hFFE0);
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, 8'h00, {30'h0, s[0], 1'b1});
      repeat (120) @(posedge hclk);
      chk("dir", 32'h1, {31'h0, dir_out});
      xfer(1'b1, 8'h00, 32'h0);
      // An immediate stop still needs a few cycles to zero velocity and leave the stop state
      repeat (2) @(posedge hclk);
      rchk("stopping", 8'h10, 32'h1, {31'h0, ~s[0]});
      repeat (150) @(posedge hclk);
      rchk("stopped", 8'h10, 32'h7, 32'h4);
    end
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h00, 32'h5);
    @(posedge hclk);
    @(negedge hclk);
    chk("drv_pin", 32'h1, {31'h0, drive_enable});
    rchk("wait_rdy", 8'h10, 32'h1, 32'h0);
    repeat (20) @(posedge hclk);
    rchk("en_drv", 8'h10, 32'h11, 32'h11);
    drive_fault <= 1'b1;
    repeat (10) @(posedge hclk);
    rchk("fault", 8'h10, 32'h9, 32'h8);
    ack();
    repeat (10) @(posedge hclk);
    rchk("ack_fail", 8'h10, 32'h1C8, 32'h108);
    chk("cause_op", 32'h00028002, {detail, cause});
    drive_fault <= 1'b0;
    ack();
    rchk("ack_busy", 8'h10, 32'h40, 32'h40);
    repeat (10) @(posedge hclk);
    rchk("ack_ok", 8'h10, 32'h1C8, 32'h80);
    xfer(1'b1, 8'h0C, 32'h0);
    ack();
    repeat (10) @(posedge hclk);
    chk("cause_cfg", 32'h00018001, {detail, cause});
    xfer(1'b1, 8'h0C, 32'h10);
    ack();
    repeat (30) @(posedge hclk);
    rchk("cfg_ok", 8'h10, 32'h1C9, 32'h81);
    for (int m = 2; m < 4; m++) begin
      xfer(1'b1, 8'h00, {25'h0, m[1:0], 5'h05});
      p0 = npulse;
      xfer(1'b1, 8'h00, {25'h0, m[1:0], 5'h15});
      repeat (120) @(posedge hclk);
      rchk("home_busy", 8'h10, 32'h200, 32'h200);
      chk("moved", {31'h0, m == 3}, {31'h0, npulse != p0});
      ref_switch <= 1'b1;
      repeat (10) @(posedge hclk);
      rchk("homed_sw", 8'h10, 32'h620, 32'h420);
      rchk("pos_sw", 8'h14, 32'hFFFFFFFF, 32'h100);
      ref_switch <= 1'b0;
    end
    report_and_stop();
  end
endmodule : aerhc_tb_top
